// file: design/i2c_expander_defines.svh
`ifndef I2C_EXPANDER_DEFINES_SVH
`define I2C_EXPANDER_DEFINES_SVH

// responder address, strap selects the low bit
`define ADDR_STRAP_LOW      7'h20
`define ADDR_STRAP_HIGH     7'h21
`define GENERAL_CALL_ADDR   8'h00
`define SOFT_RESET_BYTE     8'h06

// command codes held in the pointer
`define CMD_PIN_LEVEL_IN_0  8'h00
`define CMD_PIN_LEVEL_IN_1  8'h01
`define CMD_DRIVE_VALUE_0   8'h02
`define CMD_DRIVE_VALUE_1   8'h03
`define CMD_INVERT_IN_0     8'h04
`define CMD_INVERT_IN_1     8'h05
`define CMD_DIRECTION_0     8'h06
`define CMD_DIRECTION_1     8'h07
`define CMD_DRIVE_LEVEL_0A  8'h40
`define CMD_DRIVE_LEVEL_0B  8'h41
`define CMD_DRIVE_LEVEL_1A  8'h42
`define CMD_DRIVE_LEVEL_1B  8'h43
`define CMD_LATCH_ENABLE_0  8'h44
`define CMD_LATCH_ENABLE_1  8'h45
`define CMD_PULL_ENABLE_0   8'h46
`define CMD_PULL_ENABLE_1   8'h47
`define CMD_PULL_DIR_0      8'h48
`define CMD_PULL_DIR_1      8'h49
`define CMD_IRQ_MASK_0      8'h4a
`define CMD_IRQ_MASK_1      8'h4b
`define CMD_IRQ_SOURCE_0    8'h4c
`define CMD_IRQ_SOURCE_1    8'h4d
`define CMD_OUTPUT_MODE     8'h4f

// reset values
`define POINTER_RESET       8'h00
`define BYTE_ALL_ONES       8'hff
`define BYTE_ALL_ZEROS      8'h00
`define LEVEL_ALL_FULL      32'hffff_ffff

// bit counting within a byte
`define BITS_PER_BYTE       4'h8
`define LAST_TX_BIT         4'h7
`define MSB_BIT             7

`endif

// file: design/i2c_expander_pkg.sv
package i2c_expander_pkg;

	// responder states, gray coded along the usual path
	typedef enum logic [2:0] {
		st_idle     = 3'h0,
		st_addr     = 3'h1,
		st_addr_ack = 3'h3,
		st_wr_byte  = 3'h2,
		st_wr_ack   = 3'h6,
		st_rd_byte  = 3'h7,
		st_rd_ack   = 3'h5,
		st_ignore   = 3'h4
	} link_state_type;

	// filtered bus line levels
	typedef struct packed {
		logic scl;
		logic sda;
	} bus_lines_type;

	// extended pin configuration handed to the pin logic
	typedef struct packed {
		logic [31:0] drive_level;
		logic [15:0] latch_enable;
		logic [15:0] pull_enable;
		logic [15:0] pull_direction;
		logic [15:0] irq_mask;
		logic [7:0]  output_mode;
	} port_config_type;

endpackage

// file: design/i2c_expander_register_map.sv
`timescale 1ns/1ps
`include "i2c_expander_defines.svh"
// What this block does
// - answer at 0x20 with strap low, 0x21 with strap high
// - address lsb one means read, zero means write
// - first byte after write address ack is stored as pointer
// - pointer bit 6 clear selects core registers 00 to 07
// - pointer bit 6 set selects extended registers 40 to 4f
// - only first write data byte loads pointer; reads carry no command
// - pointer unchanged across reads; same register returned repeatedly
// - pointer resets to 00 on power-up, hardware or software reset
// - drive strength registers 40 to 43 reset all ones
// - input latch enables 44 and 45 reset all zeros
// - pull enables 46 and 47 reset all zeros
// - pull direction selects 48 and 49 reset all ones
// - interrupt masks 4a and 4b reset all ones
// - interrupt status 4c and 4d read only, reset zero
// - output mode register 4f resets zero
// - writes to input level registers ignored
// - direction bit one makes pin input, zero output
// - two-bit drive field per pin: quarter, half, three-quarter, full
// - general call with single byte 06 then stop resets everything
module i2c_expander_register_map (
	// clock and reset
	input  wire logic                             clock,
	input  wire logic                             reset,
	// address strap pin
	input  wire logic                             addr_strap,
	// bus lines, sda open drain
	input  wire logic                             scl_in,
	input  wire logic                             sda_in,
	output logic                                  sda_out,
	output logic                                  sda_oe,
	// port pins and interrupt flags from the pin logic
	input  wire logic [15:0]                      pin_level,
	input  wire logic [15:0]                      irq_flags,
	// configuration to the pin logic
	output logic [15:0]                           drive_value,
	output logic [15:0]                           direction,
	output logic [15:0]                           invert_in,
	output i2c_expander_pkg::port_config_type     port_config
);

	// three-stage synchronisers for bus lines and pins
	logic [2:0]                       scl_sync;
	logic [2:0]                       sda_sync;
	logic [2:0]                       strap_sync;
	logic [15:0]                      pin_sync [3];
	i2c_expander_pkg::bus_lines_type  lines;
	i2c_expander_pkg::bus_lines_type  lines_prev;
	logic [15:0]                      pin_filtered;

	// protocol state
	i2c_expander_pkg::link_state_type state;
	logic [3:0]                       bit_count;
	logic [7:0]                       shift_in;
	logic [7:0]                       shift_out;
	logic                             general_call;
	logic                             first_byte;
	logic                             reset_armed;
	logic                             soft_reset;
	logic                             pointer_load;
	logic                             register_write;
	logic [7:0]                       write_data;
	logic [7:0]                       pointer;
	logic [7:0]                       read_data;
	logic [15:0]                      irq_source;
	logic [6:0]                       own_address;
	logic                             clear_all;

	// edge events on the filtered lines
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	assign clear_all  = reset | soft_reset;
	assign scl_rise   = lines.scl & ~lines_prev.scl;
	assign scl_fall   = ~lines.scl & lines_prev.scl;
	assign start_seen = lines.scl & lines_prev.scl & lines_prev.sda & ~lines.sda;
	assign stop_seen  = lines.scl & lines_prev.scl & ~lines_prev.sda & lines.sda;

	// bus line and strap synchronisers; a level is taken once stages two and three agree
	always_ff @(posedge clock) begin
		if (reset) begin
			scl_sync   <= 3'h7;
			sda_sync   <= 3'h7;
			strap_sync <= 3'h0;
			own_address <= `ADDR_STRAP_LOW;
			lines      <= '{scl: 1'b1, sda: 1'b1};
			lines_prev <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			scl_sync   <= {scl_sync[1:0], scl_in};
			sda_sync   <= {sda_sync[1:0], sda_in};
			strap_sync <= {strap_sync[1:0], addr_strap};
			lines_prev <= lines;
			if (scl_sync[1] == scl_sync[2]) begin
				lines.scl <= scl_sync[2];
			end
			if (sda_sync[1] == sda_sync[2]) begin
				lines.sda <= sda_sync[2];
			end
			// strap picks address; the strap is a pin, so it is filtered too
			if (strap_sync[1] == strap_sync[2]) begin
				own_address <= strap_sync[2] ? `ADDR_STRAP_HIGH : `ADDR_STRAP_LOW;
			end
		end
	end

	// pin synchronisers, same agreement filter per bit
	always_ff @(posedge clock) begin
		if (reset) begin
			pin_sync     <= '{default: 16'h0000};
			pin_filtered <= 16'h0000;
		end else begin
			pin_sync[0] <= pin_level;
			pin_sync[1] <= pin_sync[0];
			pin_sync[2] <= pin_sync[1];
			for (int i = 0; i < 16; i++) begin
				if (pin_sync[1][i] == pin_sync[2][i]) begin
					pin_filtered[i] <= pin_sync[2][i];
				end
			end
		end
	end

	// sda output is always low when enabled; open drain only pulls down
	always_ff @(posedge clock) begin
		sda_out <= 1'b0;
	end

	// byte-level responder sequencer
	always_ff @(posedge clock) begin
		if (clear_all) begin
			state          <= i2c_expander_pkg::st_idle;
			bit_count      <= 4'h0;
			shift_in       <= 8'h00;
			shift_out      <= 8'h00;
			sda_oe         <= 1'b0;
			general_call   <= 1'b0;
			first_byte     <= 1'b0;
			reset_armed    <= 1'b0;
			soft_reset     <= 1'b0;
			pointer_load   <= 1'b0;
			register_write <= 1'b0;
			write_data     <= 8'h00;
		end else begin
			pointer_load   <= 1'b0;
			register_write <= 1'b0;
			if (start_seen) begin
				// a repeated start abandons any pending general call reset
				state       <= i2c_expander_pkg::st_addr;
				bit_count   <= 4'h0;
				sda_oe      <= 1'b0;
				reset_armed <= 1'b0;
			end else if (stop_seen) begin
				state       <= i2c_expander_pkg::st_idle;
				sda_oe      <= 1'b0;
				soft_reset  <= reset_armed;
				reset_armed <= 1'b0;
			end else begin
				unique case (state)
					i2c_expander_pkg::st_idle: ; // waits for a start
					i2c_expander_pkg::st_addr: begin
						if (scl_rise) begin
							shift_in  <= {shift_in[6:0], lines.sda};
							bit_count <= bit_count + 4'h1;
						end else if (scl_fall && bit_count == `BITS_PER_BYTE) begin
							if (shift_in[7:1] == own_address) begin
								sda_oe       <= 1'b1;
								general_call <= 1'b0;
								state        <= i2c_expander_pkg::st_addr_ack;
							end else if (shift_in == `GENERAL_CALL_ADDR) begin
								sda_oe       <= 1'b1;
								general_call <= 1'b1;
								state        <= i2c_expander_pkg::st_addr_ack;
							end else begin
								// foreign address or general call read: no answer
								state <= i2c_expander_pkg::st_ignore;
							end
						end
					end
					i2c_expander_pkg::st_addr_ack: begin
						if (scl_fall) begin
							bit_count <= 4'h0;
							if (shift_in[0] && !general_call) begin
								shift_out <= read_data;
								sda_oe    <= ~read_data[`MSB_BIT];
								state     <= i2c_expander_pkg::st_rd_byte;
							end else begin
								sda_oe     <= 1'b0;
								first_byte <= 1'b1;
								state      <= i2c_expander_pkg::st_wr_byte;
							end
						end
					end
					i2c_expander_pkg::st_wr_byte: begin
						if (scl_rise) begin
							shift_in  <= {shift_in[6:0], lines.sda};
							bit_count <= bit_count + 4'h1;
						end else if (scl_fall && bit_count == `BITS_PER_BYTE) begin
							first_byte <= 1'b0;
							if (general_call) begin
								if (first_byte && shift_in == `SOFT_RESET_BYTE) begin
									sda_oe      <= 1'b1;
									reset_armed <= 1'b1;
									state       <= i2c_expander_pkg::st_wr_ack;
								end else begin
									reset_armed <= 1'b0;
									state       <= i2c_expander_pkg::st_ignore;
								end
							end else begin
								sda_oe         <= 1'b1;
								write_data     <= shift_in;
								pointer_load   <= first_byte;
								register_write <= ~first_byte;
								state          <= i2c_expander_pkg::st_wr_ack;
							end
						end
					end
					i2c_expander_pkg::st_wr_ack: begin
						if (scl_fall) begin
							sda_oe    <= 1'b0;
							bit_count <= 4'h0;
							state     <= i2c_expander_pkg::st_wr_byte;
						end
					end
					i2c_expander_pkg::st_rd_byte: begin
						if (scl_fall) begin
							bit_count <= bit_count + 4'h1;
							if (bit_count == `LAST_TX_BIT) begin
								sda_oe <= 1'b0;
								state  <= i2c_expander_pkg::st_rd_ack;
							end else begin
								shift_out <= {shift_out[6:0], 1'b0};
								sda_oe    <= ~shift_out[`MSB_BIT - 1];
							end
						end
					end
					i2c_expander_pkg::st_rd_ack: begin
						if (scl_rise && lines.sda) begin
							// controller nack ends the read
							state <= i2c_expander_pkg::st_ignore;
						end else if (scl_fall) begin
							bit_count <= 4'h0;
							shift_out <= read_data;
							sda_oe    <= ~read_data[`MSB_BIT];
							state     <= i2c_expander_pkg::st_rd_byte;
						end
					end
					i2c_expander_pkg::st_ignore: begin
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// command pointer
	always_ff @(posedge clock) begin
		if (clear_all) begin
			pointer <= `POINTER_RESET;
		end else if (pointer_load) begin
			// only the command byte loads it
			pointer <= write_data;
		end
	end

	// core registers; direction bit one means input
	always_ff @(posedge clock) begin
		if (clear_all) begin
			drive_value <= {`BYTE_ALL_ONES, `BYTE_ALL_ONES};
			invert_in   <= {`BYTE_ALL_ZEROS, `BYTE_ALL_ZEROS};
			direction   <= {`BYTE_ALL_ONES, `BYTE_ALL_ONES};
		end else if (register_write) begin
			// core decode; input levels not writable
			unique case (pointer)
				`CMD_DRIVE_VALUE_0: drive_value[7:0]  <= write_data;
				`CMD_DRIVE_VALUE_1: drive_value[15:8] <= write_data;
				`CMD_INVERT_IN_0:   invert_in[7:0]    <= write_data;
				`CMD_INVERT_IN_1:   invert_in[15:8]   <= write_data;
				`CMD_DIRECTION_0:   direction[7:0]    <= write_data;
				`CMD_DIRECTION_1:   direction[15:8]   <= write_data;
				default: ;
			endcase
		end
	end

	// extended registers; two drive bits per pin, 11 is full strength
	always_ff @(posedge clock) begin
		if (clear_all) begin
			port_config.drive_level    <= `LEVEL_ALL_FULL;
			port_config.latch_enable   <= {`BYTE_ALL_ZEROS, `BYTE_ALL_ZEROS};
			port_config.pull_enable    <= {`BYTE_ALL_ZEROS, `BYTE_ALL_ZEROS};
			port_config.pull_direction <= {`BYTE_ALL_ONES, `BYTE_ALL_ONES};
			port_config.irq_mask       <= {`BYTE_ALL_ONES, `BYTE_ALL_ONES};
			port_config.output_mode    <= `BYTE_ALL_ZEROS;
		end else if (register_write) begin
			// extended decode; unlisted codes change nothing
			unique case (pointer)
				`CMD_DRIVE_LEVEL_0A: port_config.drive_level[7:0]     <= write_data;
				`CMD_DRIVE_LEVEL_0B: port_config.drive_level[15:8]    <= write_data;
				`CMD_DRIVE_LEVEL_1A: port_config.drive_level[23:16]   <= write_data;
				`CMD_DRIVE_LEVEL_1B: port_config.drive_level[31:24]   <= write_data;
				`CMD_LATCH_ENABLE_0: port_config.latch_enable[7:0]    <= write_data;
				`CMD_LATCH_ENABLE_1: port_config.latch_enable[15:8]   <= write_data;
				`CMD_PULL_ENABLE_0:  port_config.pull_enable[7:0]     <= write_data;
				`CMD_PULL_ENABLE_1:  port_config.pull_enable[15:8]    <= write_data;
				`CMD_PULL_DIR_0:     port_config.pull_direction[7:0]  <= write_data;
				`CMD_PULL_DIR_1:     port_config.pull_direction[15:8] <= write_data;
				`CMD_IRQ_MASK_0:     port_config.irq_mask[7:0]        <= write_data;
				`CMD_IRQ_MASK_1:     port_config.irq_mask[15:8]       <= write_data;
				`CMD_OUTPUT_MODE:    port_config.output_mode          <= write_data;
				default: ;
			endcase
		end
	end

	// interrupt status copy, refreshed from the pin logic every cycle
	always_ff @(posedge clock) begin
		if (clear_all) begin
			irq_source <= {`BYTE_ALL_ZEROS, `BYTE_ALL_ZEROS};
		end else begin
			irq_source <= irq_flags;
		end
	end

	// read mux; input levels are pin levels with polarity applied
	always_comb begin
		unique case (pointer)
			`CMD_PIN_LEVEL_IN_0: read_data = pin_filtered[7:0] ^ invert_in[7:0];
			`CMD_PIN_LEVEL_IN_1: read_data = pin_filtered[15:8] ^ invert_in[15:8];
			`CMD_DRIVE_VALUE_0:  read_data = drive_value[7:0];
			`CMD_DRIVE_VALUE_1:  read_data = drive_value[15:8];
			`CMD_INVERT_IN_0:    read_data = invert_in[7:0];
			`CMD_INVERT_IN_1:    read_data = invert_in[15:8];
			`CMD_DIRECTION_0:    read_data = direction[7:0];
			`CMD_DIRECTION_1:    read_data = direction[15:8];
			`CMD_DRIVE_LEVEL_0A: read_data = port_config.drive_level[7:0];
			`CMD_DRIVE_LEVEL_0B: read_data = port_config.drive_level[15:8];
			`CMD_DRIVE_LEVEL_1A: read_data = port_config.drive_level[23:16];
			`CMD_DRIVE_LEVEL_1B: read_data = port_config.drive_level[31:24];
			`CMD_LATCH_ENABLE_0: read_data = port_config.latch_enable[7:0];
			`CMD_LATCH_ENABLE_1: read_data = port_config.latch_enable[15:8];
			`CMD_PULL_ENABLE_0:  read_data = port_config.pull_enable[7:0];
			`CMD_PULL_ENABLE_1:  read_data = port_config.pull_enable[15:8];
			`CMD_PULL_DIR_0:     read_data = port_config.pull_direction[7:0];
			`CMD_PULL_DIR_1:     read_data = port_config.pull_direction[15:8];
			`CMD_IRQ_MASK_0:     read_data = port_config.irq_mask[7:0];
			`CMD_IRQ_MASK_1:     read_data = port_config.irq_mask[15:8];
			`CMD_IRQ_SOURCE_0:   read_data = irq_source[7:0];
			`CMD_IRQ_SOURCE_1:   read_data = irq_source[15:8];
			`CMD_OUTPUT_MODE:    read_data = port_config.output_mode;
			default:             read_data = 8'h00;
		endcase
	end

endmodule // i2c_expander_register_map

// file: testbench/i2c_expander_register_map_sva.sv
`timescale 1ns/1ps
// pin-level watcher for the responder
module i2c_expander_register_map_sva (
	// clock and reset
	input wire logic                              clock,
	input wire logic                              reset,
	// bus lines and strap
	input wire logic                              addr_strap,
	input wire logic                              scl_in,
	input wire logic                              sda_in,
	input wire logic                              sda_out,
	input wire logic                              sda_oe,
	// port side
	input wire logic [15:0]                       pin_level,
	input wire logic [15:0]                       irq_flags,
	input wire logic [15:0]                       drive_value,
	input wire logic [15:0]                       direction,
	input wire logic [15:0]                       invert_in,
	input wire i2c_expander_pkg::port_config_type port_config
);
	localparam logic [103:0] cfg_dflt = {32'hffff_ffff, 16'h0000, 16'h0000, 16'hffff, 16'hffff, 8'h00};
	logic [4:0] scl_high_cnt;

	// scl high run length, saturates so idle never wraps
	always_ff @(posedge clock) begin
		if (reset || !scl_in)
			scl_high_cnt <= 5'h00;
		else if (scl_high_cnt != 5'h1f)
			scl_high_cnt <= scl_high_cnt + 5'h01;
	end

	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	AST_CFG_AFTER_RESET: assert property ($fell(reset) |-> port_config == cfg_dflt)
		else $error("extended registers not at defaults after reset");
	AST_CORE_AFTER_RESET: assert property ($fell(reset) |->
		drive_value == 16'hffff && direction == 16'hffff && invert_in == 16'h0000 && !sda_oe)
		else $error("core registers or sda not idle after reset");
	AST_WRITE_IN_ACK: assert property ($changed({drive_value, direction, invert_in, port_config}) |->
		sda_oe || {drive_value, direction, invert_in, port_config} == {16'hffff, 16'hffff, 16'h0000, cfg_dflt})
		else $error("register changed outside an acknowledge");
	AST_WRITE_SPACING: assert property ($changed(drive_value) |=> $stable(drive_value)[*8])
		else $error("output register changed twice within one bit");
	AST_OE_RELEASE: assert property (sda_oe |-> ##[1:90] !sda_oe)
		else $error("sda held low too long");
	AST_IDLE_QUIET: assert property (scl_high_cnt >= 5'd12 |-> !sda_oe)
		else $error("sda driven while bus idle");
	AST_OE_CHANGE_SCL_LOW: assert property ($changed(sda_oe) |->
		!(scl_in && $past(scl_in) && $past(scl_in, 2)))
		else $error("sda changed during scl high");
	AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
		else $error("open drain data not low");

	// main scenarios reached
	cover property ($rose(sda_oe));
	cover property ($changed(drive_value));
	cover property ($changed(port_config));
endmodule // i2c_expander_register_map_sva

bind i2c_expander_register_map i2c_expander_register_map_sva u_sva (.clock(clock), .reset(reset),
	.addr_strap(addr_strap), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.pin_level(pin_level), .irq_flags(irq_flags), .drive_value(drive_value), .direction(direction),
	.invert_in(invert_in), .port_config(port_config));

// file: testbench/i2c_ctrl_model.sv
`timescale 1ns/1ps
// behavioural bus controller; scl stands high outside frames
module i2c_ctrl_model (
	// clock
	input  wire logic clock,
	// bus
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_low
);
	// idle bus
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// 6 clocks low, 2 high; the low phase outlasts the responder's filter and answer delay
	task automatic bit_xfer(input logic b, output logic r);
		tick(1);
		sda_low = !b;
		tick(5);
		scl = 1'b1;
		tick(1);
		r = sda_line;
		tick(1);
		scl = 1'b0;
	endtask

	// start, also serves as repeated start
	task automatic start();
		tick(1);
		sda_low = 1'b0;
		tick(5);
		scl = 1'b1;
		tick(4);
		sda_low = 1'b1;
		tick(4);
		scl = 1'b0;
	endtask

	task automatic stop();
		tick(1);
		sda_low = 1'b1;
		tick(5);
		scl = 1'b1;
		tick(4);
		sda_low = 1'b0;
		tick(4);
	endtask

	// byte out msb first, ninth bit released for the answer
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_xfer(d[i], r);
		bit_xfer(1'b1, r);
		ack = !r;
	endtask

	// byte in, then ack or nack from the controller
	task automatic recv(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, r);
			d[i] = r;
		end
		bit_xfer(!ack, r);
	endtask
endmodule // i2c_ctrl_model

// file: testbench/i2c_expander_register_map_test.sv
`timescale 1ns/1ps
module i2c_expander_register_map_test;
	logic                              clock, reset, addr_strap, scl, sda_low, sda_out, sda_oe, ack;
	logic [15:0]                       pin_level, irq_flags, drive_value, direction, invert_in;
	i2c_expander_pkg::port_config_type port_config;
	logic [7:0]                        exp_reg [256];
	logic [7:0]                        rd_data;
	int                                n_mismatch, check_count;
	int unsigned                       seed;
	logic [7:0]                        codes [27] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
		8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d,
		8'h4f, 8'h08, 8'h3f, 8'h4e, 8'h80};
	// pull-up on sda, either party pulls low
	wire sda_line = !sda_low && (!sda_oe || sda_out);

	i2c_expander_register_map u_dut (.clock(clock), .reset(reset), .addr_strap(addr_strap), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .pin_level(pin_level), .irq_flags(irq_flags),
		.drive_value(drive_value), .direction(direction), .invert_in(invert_in), .port_config(port_config));
	i2c_ctrl_model u_ctrl (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

	// 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	function automatic logic [7:0] dflt(input logic [7:0] c);
		case (c)
			8'h02, 8'h03, 8'h06, 8'h07, 8'h40, 8'h41, 8'h42, 8'h43, 8'h48, 8'h49, 8'h4a, 8'h4b: dflt = 8'hff;
			default: dflt = 8'h00;
		endcase
	endfunction
	function automatic logic rw(input logic [7:0] c);
		rw = (c >= 8'h02 && c <= 8'h07) || (c >= 8'h40 && c <= 8'h4b) || c == 8'h4f;
	endfunction
	// input levels, status copy, unlisted reads zero
	function automatic logic [7:0] expect_rd(input logic [7:0] c);
		case (c)
			8'h00: expect_rd = pin_level[7:0] ^ exp_reg[8'h04];
			8'h01: expect_rd = pin_level[15:8] ^ exp_reg[8'h05];
			8'h4c: expect_rd = irq_flags[7:0];
			8'h4d: expect_rd = irq_flags[15:8];
			default: expect_rd = rw(c) ? exp_reg[c] : 8'h00;
		endcase
	endfunction
	function automatic logic [7:0] dev_addr();
		dev_addr = {6'h10, addr_strap, 1'b0};
	endfunction

	task automatic check(input string name, input logic [103:0] seen, input logic [103:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// address, command byte, data bytes at one pointer
	task automatic wr_bytes(input logic [7:0] c, input logic [7:0] d0, input logic [7:0] d1, input int n);
		u_ctrl.start();
		u_ctrl.send(dev_addr(), ack);
		check("address ack", ack, 1'b1);
		u_ctrl.send(c, ack);
		u_ctrl.send(d0, ack);
		if (n > 1)
			u_ctrl.send(d1, ack);
		check("data ack", ack, 1'b1);
		u_ctrl.stop();
		if (rw(c))
			exp_reg[c] = (n > 1) ? d1 : d0;
	endtask
	task automatic set_ptr(input logic [7:0] c);
		u_ctrl.start();
		u_ctrl.send(dev_addr(), ack);
		u_ctrl.send(c, ack);
		u_ctrl.stop();
	endtask
	// read at whatever the pointer holds
	task automatic rd_chk(input logic [7:0] c);
		u_ctrl.start();
		u_ctrl.send(dev_addr() | 8'h01, ack);
		u_ctrl.recv(1'b0, rd_data);
		u_ctrl.stop();
		check($sformatf("register %h", c), rd_data, expect_rd(c));
	endtask
	task automatic ptr_rd(input logic [7:0] c);
		set_ptr(c);
		rd_chk(c);
	endtask
	task automatic ports_chk();
		check("core ports", {drive_value, direction, invert_in}, {exp_reg[8'h03], exp_reg[8'h02],
			exp_reg[8'h07], exp_reg[8'h06], exp_reg[8'h05], exp_reg[8'h04]});
		check("config", port_config, {exp_reg[8'h43], exp_reg[8'h42], exp_reg[8'h41], exp_reg[8'h40],
			exp_reg[8'h45], exp_reg[8'h44], exp_reg[8'h47], exp_reg[8'h46], exp_reg[8'h49], exp_reg[8'h48],
			exp_reg[8'h4b], exp_reg[8'h4a], exp_reg[8'h4f]});
	endtask
	// general call with one data byte
	task automatic gcall(input logic [7:0] d, input logic exp_ack);
		u_ctrl.start();
		u_ctrl.send(8'h00, ack);
		u_ctrl.send(d, ack);
		check("general call ack", ack, exp_ack);
		u_ctrl.stop();
	endtask

	// hang guard, about twice the expected run
	initial begin
		repeat (60000) @(posedge clock);
		n_mismatch++;
		complete_run();
	end

	// main sequence
	initial begin
		reset = 1'b1;
		addr_strap = 1'b0;
		seed = $urandom(32'h9cc6);
		pin_level = 16'($urandom);
		irq_flags = 16'($urandom);
		for (int i = 0; i < 256; i++)
			exp_reg[i] = dflt(8'(i));
		repeat (4) @(posedge clock);
		#1 reset = 1'b0;
		u_ctrl.tick(4);
		ports_chk();
		foreach (codes[i]) ptr_rd(codes[i]);
		$display("test reset values done");
		// strap high, random data everywhere, read-only and unlisted too
		addr_strap = 1'b1;
		pin_level = 16'($urandom);
		foreach (codes[i]) wr_bytes(codes[i], 8'($urandom), 8'h00, 1);
		foreach (codes[i]) ptr_rd(codes[i]);
		ports_chk();
		$display("test random writes done");
		// second data byte lands on the same register, reads keep the pointer
		wr_bytes(8'h02, 8'haa, 8'h55, 2);
		ports_chk();
		set_ptr(8'h4f);
		rd_chk(8'h4f);
		rd_chk(8'h4f);
		$display("test pointer hold done");
		// the other strap address is refused
		for (int s = 0; s < 2; s++) begin
			addr_strap = s[0];
			u_ctrl.start();
			u_ctrl.send(dev_addr() ^ 8'h02, ack);
			check("foreign address", ack, 1'b0);
			u_ctrl.stop();
		end
		$display("test address select done");
		// refused general calls change nothing, then a real one
		u_ctrl.start();
		u_ctrl.send(8'h01, ack);
		check("general call read", ack, 1'b0);
		u_ctrl.stop();
		gcall(8'h07, 1'b0);
		ports_chk();
		gcall(8'h06, 1'b1);
		for (int i = 0; i < 256; i++)
			exp_reg[i] = dflt(8'(i));
		u_ctrl.tick(4);
		ports_chk();
		rd_chk(8'h00);
		$display("test software reset done");
		wr_bytes(8'h04, 8'h3c, 8'h00, 1);
		set_ptr(8'h4c);
		reset = 1'b1;
		u_ctrl.tick(1);
		reset = 1'b0;
		exp_reg[8'h04] = 8'h00;
		u_ctrl.tick(4);
		rd_chk(8'h00);
		$display("test hardware reset done");
		complete_run();
	end
endmodule // i2c_expander_register_map_test
